// >>> rtl/lane_align_pkg.sv
// Constants and types shared by both ends of the four-lane sample link.
// Assumes one frame clock for both ends and one octet per lane per frame.
`default_nettype none
package lane_align_pkg;
  // ==========================================================
  // Link geometry
  localparam int LANES = 4;
  localparam int OCTET_W = 8;
  localparam int SAMPLE_W = 12;
  localparam int FRAMES_PER_MF = 32;
  localparam logic [4:0] MF_LAST = 5'h1F;
  localparam logic [4:0] MF_FIRST = 5'h00;
  localparam int ILA_MULTIFRAMES = 4;
  localparam logic [1:0] ILA_MF_LAST = 2'h3;
  localparam logic [4:0] SYNC_FRAMES_LAST = 5'h0F;
  // ==========================================================
  // Control characters
  localparam logic [7:0] CHAR_ALIGN = 8'h7C;
  localparam logic [7:0] CHAR_COMMA = 8'hBC;
  // ==========================================================
  // Deskew, monitoring, concealment, sample delay
  localparam int DESKEW_DEPTH = 16;
  localparam int MAX_SKEW = 7;
  localparam int LANE_WORD_W = 10;
  localparam logic [1:0] MISS_ONE = 2'h1;
  localparam logic [1:0] HOLD_SCRAMBLED = 2'h1;
  localparam logic [1:0] HOLD_PLAIN = 2'h0;
  localparam int DELAY_TAPS = 8;
  localparam logic [2:0] DELAY_MAX = 3'h7;
  // ==========================================================
  // Modes and states
  typedef enum logic [1:0] {
    MDS_OFF = 2'b00,
    MDS_MASTER = 2'b01,
    MDS_SLAVE = 2'b10,
    MDS_ALL_SLAVE = 2'b11
  } mds_mode_e;
  typedef enum logic [1:0] {
    RX_WAIT_LOCK = 2'b00,
    RX_ILA = 2'b01,
    RX_RUN = 2'b10
  } rx_state_e;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SYNC = 2'b01,
    TX_ILA = 2'b10,
    TX_DATA = 2'b11
  } tx_state_e;
endpackage
`default_nettype wire

// >>> rtl/lane_align_rx.sv
// Receiver end: lane deskew, alignment monitoring, multi-device sample
// alignment and frame assembly. Assumes lane lock comes from the deserialiser.
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Lane deskew FIFO
module deskew_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic [AW:0] fill;
  assign fill = wptr - rptr;
  assign in_ready = fill != (AW+1)'(DEPTH);
  assign out_valid = fill != '0;
  assign out_data = mem[rptr[AW-1:0]];
  always_ff @(posedge clk)
  begin
    if (in_valid && in_ready)
    begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst || flush)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
      begin
        wptr <= wptr + 1'b1;
      end
      if (out_valid && out_ready)
      begin
        rptr <= rptr + 1'b1;
      end
    end
  end
endmodule
// ==========================================================
// Receiver top
module lane_align_rx (
  input wire logic MCLK,
  input wire logic SRST,
  lane_link_if.rx LINK,
  input wire logic [3:0] LANE_LOCK,
  input wire logic [1:0] ALIGN_TRIGGER_SELECT,
  input wire logic MANUAL_ALIGN,
  input wire logic SCRAMBLE_EN,
  input wire logic [1:0] MDS_MODE,
  input wire logic MDS_IN_P,
  input wire logic MDS_IN_N,
  input wire logic BUF_ERR_CLEAR,
  output logic [11:0] I_SAMPLE,
  output logic [11:0] Q_SAMPLE,
  output logic SAMPLE_VALID,
  output logic [3:0] LANE_BUFFER_ERROR_FLAG,
  output logic ALIGNED,
  output logic MDS_OUT_P,
  output logic MDS_OUT_N,
  output logic [2:0] MDS_DELAY
);
  lane_align_pkg::rx_state_e state;
  logic [3:0] lane_go;
  logic [3:0] is_align;
  logic [3:0] in_ready;
  logic [3:0] out_valid;
  logic [3:0] buf_ovf;
  logic [3:0] buf_empty;
  logic [3:0] out_align;
  logic [3:0] miss_hit;
  logic [2:0] a_cnt [4];
  logic [1:0] miss_cnt [4];
  logic [9:0] lane_word [4];
  logic [4:0] mon_cnt;
  logic reading;
  logic realign;
  logic flush;
  logic is_slave;
  assign reading = (state == lane_align_pkg::RX_RUN) && (&out_valid);
  assign flush = realign || (state == lane_align_pkg::RX_WAIT_LOCK);
  // ==========================================================
  // Per-lane capture and deskew buffers
  genvar l;
  generate
    for (l = 0; l < lane_align_pkg::LANES; l++)
    begin : g_lane
      assign is_align[l] = LANE_LOCK[l] && LINK.lane_ctrl[l]
        && (LINK.lane_data[8*l +: 8] == lane_align_pkg::CHAR_ALIGN);
      deskew_fifo #(
        .WIDTH(lane_align_pkg::LANE_WORD_W),
        .DEPTH(lane_align_pkg::DESKEW_DEPTH)
      ) u_fifo (
        .clk(MCLK),
        .rst(SRST),
        .flush(flush),
        .in_valid(lane_go[l]),
        .in_data({LINK.lane_nit_err[l] | LINK.lane_kout_unexp[l], LINK.lane_ctrl[l], LINK.lane_data[8*l +: 8]}),
        .in_ready(in_ready[l]),
        .out_valid(out_valid[l]),
        .out_data(lane_word[l]),
        .out_ready(reading)
      );
      assign buf_ovf[l] = lane_go[l] && !in_ready[l];
      assign buf_empty[l] = (state == lane_align_pkg::RX_RUN) && !out_valid[l];
      assign out_align[l] = lane_word[l][8] && (lane_word[l][7:0] == lane_align_pkg::CHAR_ALIGN);
      assign miss_hit[l] = reading && out_align[l] && (mon_cnt != lane_align_pkg::MF_LAST)
        && (miss_cnt[l] == lane_align_pkg::MISS_ONE);
    end
  endgenerate
  assign realign = (state != lane_align_pkg::RX_WAIT_LOCK) && (|buf_ovf || |buf_empty || |miss_hit);
  // ==========================================================
  // Alignment state
  always_ff @(posedge MCLK)
  begin
    if (SRST || !(&LANE_LOCK))
    begin
      state <= lane_align_pkg::RX_WAIT_LOCK;
    end
    else
    begin
      case (state)
        lane_align_pkg::RX_WAIT_LOCK: state <= lane_align_pkg::RX_ILA;
        lane_align_pkg::RX_ILA: if (!realign && (&lane_go)) state <= lane_align_pkg::RX_RUN;
        lane_align_pkg::RX_RUN: if (realign) state <= lane_align_pkg::RX_ILA;
        default: state <= lane_align_pkg::RX_WAIT_LOCK;
      endcase
    end
  end
  always_ff @(posedge MCLK)
  begin
    for (int i = 0; i < lane_align_pkg::LANES; i++)
    begin
      if (SRST || flush)
      begin
        lane_go[i] <= 1'b0;
        a_cnt[i] <= '0;
      end
      else if (state == lane_align_pkg::RX_ILA && !lane_go[i])
      begin
        if (MANUAL_ALIGN)
        begin
          lane_go[i] <= 1'b1;
        end
        else if (is_align[i] && a_cnt[i] == {1'b0, ALIGN_TRIGGER_SELECT})
        begin
          lane_go[i] <= 1'b1;
        end
        else if (is_align[i])
        begin
          a_cnt[i] <= a_cnt[i] + 3'h1;
        end
      end
    end
  end
  // ==========================================================
  // Alignment monitoring
  always_ff @(posedge MCLK)
  begin
    if (SRST || state != lane_align_pkg::RX_RUN)
    begin
      mon_cnt <= '0;
    end
    else if (reading)
    begin
      mon_cnt <= mon_cnt + 5'h01;
    end
  end
  always_ff @(posedge MCLK)
  begin
    for (int i = 0; i < lane_align_pkg::LANES; i++)
    begin
      if (SRST || state != lane_align_pkg::RX_RUN)
      begin
        miss_cnt[i] <= '0;
      end
      else if (reading && out_align[i])
      begin
        miss_cnt[i] <= (mon_cnt == lane_align_pkg::MF_LAST) ? 2'h0 : lane_align_pkg::MISS_ONE;
      end
    end
  end
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      LANE_BUFFER_ERROR_FLAG <= '0;
    end
    else
    begin
      LANE_BUFFER_ERROR_FLAG <= (LANE_BUFFER_ERROR_FLAG & ~{4{BUF_ERR_CLEAR}}) | buf_ovf | buf_empty;
    end
  end
  // ==========================================================
  // Frame assembly and error concealment
  logic [11:0] raw [2];
  logic [1:0] ch_err;
  logic [11:0] prev [2];
  logic [11:0] cur [2];
  logic [1:0] hold [2];
  logic cur_valid;
  logic cur_ref;
  assign raw[0] = {lane_word[0][7:0], lane_word[1][7:4]};
  assign raw[1] = {lane_word[2][7:0], lane_word[3][7:4]};
  assign ch_err[0] = lane_word[0][9] | lane_word[1][9];
  assign ch_err[1] = lane_word[2][9] | lane_word[3][9];
  always_ff @(posedge MCLK)
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (SRST)
      begin
        prev[c] <= '0;
        cur[c] <= '0;
        hold[c] <= '0;
      end
      else if (reading && ch_err[c])
      begin
        cur[c] <= prev[c];
        hold[c] <= SCRAMBLE_EN ? lane_align_pkg::HOLD_SCRAMBLED : lane_align_pkg::HOLD_PLAIN;
      end
      else if (reading && (out_align[2*c] || out_align[2*c+1]))
      begin
        // Align character stands in for the last sample
        cur[c] <= prev[c];
      end
      else if (reading && hold[c] != 2'h0)
      begin
        cur[c] <= prev[c];
        hold[c] <= hold[c] - 2'h1;
      end
      else if (reading)
      begin
        cur[c] <= raw[c];
        prev[c] <= raw[c];
      end
    end
  end
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      cur_valid <= 1'b0;
      cur_ref <= 1'b0;
    end
    else
    begin
      cur_valid <= reading;
      cur_ref <= reading && (mon_cnt == lane_align_pkg::MF_FIRST);
    end
  end
  // ==========================================================
  // Multi-device sample delay line
  logic [11:0] dl_i [lane_align_pkg::DELAY_TAPS];
  logic [11:0] dl_q [lane_align_pkg::DELAY_TAPS];
  logic [lane_align_pkg::DELAY_TAPS-1:0] dl_v;
  logic [lane_align_pkg::DELAY_TAPS-1:0] dl_r;
  logic [2:0] tap;
  assign is_slave = (MDS_MODE == lane_align_pkg::MDS_SLAVE) || (MDS_MODE == lane_align_pkg::MDS_ALL_SLAVE);
  assign tap = is_slave ? MDS_DELAY : 3'h0;
  always_ff @(posedge MCLK)
  begin
    dl_i[0] <= cur[0];
    dl_q[0] <= cur[1];
    for (int k = 1; k < lane_align_pkg::DELAY_TAPS; k++)
    begin
      dl_i[k] <= dl_i[k-1];
      dl_q[k] <= dl_q[k-1];
    end
  end
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      dl_v <= '0;
      dl_r <= '0;
    end
    else
    begin
      dl_v <= {dl_v[lane_align_pkg::DELAY_TAPS-2:0], cur_valid};
      dl_r <= {dl_r[lane_align_pkg::DELAY_TAPS-2:0], cur_ref};
    end
  end
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      I_SAMPLE <= '0;
      Q_SAMPLE <= '0;
      SAMPLE_VALID <= 1'b0;
      ALIGNED <= 1'b0;
      MDS_OUT_P <= 1'b0;
      MDS_OUT_N <= 1'b1;
    end
    else
    begin
      I_SAMPLE <= dl_i[tap];
      Q_SAMPLE <= dl_q[tap];
      SAMPLE_VALID <= dl_v[tap] && (state == lane_align_pkg::RX_RUN);
      ALIGNED <= state == lane_align_pkg::RX_RUN;
      MDS_OUT_P <= (MDS_MODE == lane_align_pkg::MDS_MASTER) && dl_r[0];
      MDS_OUT_N <= !((MDS_MODE == lane_align_pkg::MDS_MASTER) && dl_r[0]);
    end
  end
  // ==========================================================
  // Sync input and early-late compare
  logic mds_raw;
  logic [2:0] mds_sync;
  logic ext_level;
  logic ext_rise;
  logic pend_int;
  logic pend_ext;
  assign mds_raw = (MDS_MODE == lane_align_pkg::MDS_ALL_SLAVE) ? (LINK.mds_p & ~LINK.mds_n)
    : (MDS_IN_P & ~MDS_IN_N);
  assign ext_rise = mds_sync[1] && mds_sync[2] && !ext_level;
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      mds_sync <= '0;
      ext_level <= 1'b0;
    end
    else
    begin
      mds_sync <= {mds_sync[1:0], mds_raw};
      if (mds_sync[1] == mds_sync[2])
      begin
        ext_level <= mds_sync[2];
      end
    end
  end
  always_ff @(posedge MCLK)
  begin
    if (SRST || !is_slave)
    begin
      MDS_DELAY <= '0;
      pend_int <= 1'b0;
      pend_ext <= 1'b0;
    end
    else if (ext_rise && dl_r[tap])
    begin
      pend_int <= 1'b0;
      pend_ext <= 1'b0;
    end
    else if (ext_rise)
    begin
      pend_ext <= !pend_int;
      pend_int <= 1'b0;
      if (pend_int && MDS_DELAY != lane_align_pkg::DELAY_MAX)
      begin
        MDS_DELAY <= MDS_DELAY + 3'h1;
      end
    end
    else if (dl_r[tap])
    begin
      pend_int <= !pend_ext;
      pend_ext <= 1'b0;
      if (pend_ext && MDS_DELAY != 3'h0)
      begin
        MDS_DELAY <= MDS_DELAY - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/lane_align_tx.sv
// Transmitter end: sync characters, initial alignment sequence, samples
// split across four lanes, and the sync pulse for all-slave systems.
// Assumes the receiver runs on the same frame clock.
`timescale 1ns/1ns
`default_nettype none
module lane_align_tx (
  input wire logic MCLK,
  input wire logic SRST,
  lane_link_if.tx LINK,
  input wire logic START,
  input wire logic [11:0] TX_I,
  input wire logic [11:0] TX_Q,
  input wire logic TX_VALID,
  output logic TX_READY,
  input wire logic MDS_DRIVE,
  input wire logic [4:0] MDS_LEAD,
  input wire logic [3:0] INJECT_NIT,
  input wire logic [3:0] INJECT_KOUT,
  output logic LINK_UP
);
  lane_align_pkg::tx_state_e state;
  lane_align_pkg::tx_state_e next_state;
  logic [4:0] fcnt;
  logic [4:0] next_fcnt;
  logic [1:0] mf_cnt;
  // ==========================================================
  // Sequence control
  always_comb
  begin
    next_state = state;
    next_fcnt = fcnt + 5'h01;
    case (state)
      lane_align_pkg::TX_IDLE:
      begin
        next_fcnt = '0;
        if (START) next_state = lane_align_pkg::TX_SYNC;
      end
      lane_align_pkg::TX_SYNC:
      begin
        if (fcnt == lane_align_pkg::SYNC_FRAMES_LAST)
        begin
          next_state = lane_align_pkg::TX_ILA;
          next_fcnt = '0;
        end
      end
      lane_align_pkg::TX_ILA:
      begin
        if (fcnt == lane_align_pkg::MF_LAST && mf_cnt == lane_align_pkg::ILA_MF_LAST)
        begin
          next_state = lane_align_pkg::TX_DATA;
        end
      end
      lane_align_pkg::TX_DATA: next_state = lane_align_pkg::TX_DATA;
      default: next_state = lane_align_pkg::TX_IDLE;
    endcase
    if (!START)
    begin
      next_state = lane_align_pkg::TX_IDLE;
      next_fcnt = '0;
    end
  end
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      state <= lane_align_pkg::TX_IDLE;
      fcnt <= '0;
      mf_cnt <= '0;
      TX_READY <= 1'b0;
      LINK_UP <= 1'b0;
    end
    else
    begin
      state <= next_state;
      fcnt <= next_fcnt;
      if (state != lane_align_pkg::TX_ILA)
      begin
        mf_cnt <= '0;
      end
      else if (fcnt == lane_align_pkg::MF_LAST)
      begin
        mf_cnt <= mf_cnt + 2'h1;
      end
      TX_READY <= (next_state == lane_align_pkg::TX_DATA) && (next_fcnt != lane_align_pkg::MF_LAST);
      LINK_UP <= next_state == lane_align_pkg::TX_DATA;
    end
  end
  // ==========================================================
  // Lane drive, one octet per lane per frame
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      LINK.lane_data <= '0;
      LINK.lane_ctrl <= '0;
      LINK.lane_nit_err <= '0;
      LINK.lane_kout_unexp <= '0;
      LINK.mds_p <= 1'b0;
      LINK.mds_n <= 1'b1;
    end
    else
    begin
      LINK.lane_nit_err <= (state == lane_align_pkg::TX_DATA) ? INJECT_NIT : 4'h0;
      LINK.lane_kout_unexp <= (state == lane_align_pkg::TX_DATA) ? INJECT_KOUT : 4'h0;
      LINK.mds_p <= MDS_DRIVE && (state == lane_align_pkg::TX_DATA) && (fcnt == MDS_LEAD);
      LINK.mds_n <= !(MDS_DRIVE && (state == lane_align_pkg::TX_DATA) && (fcnt == MDS_LEAD));
      case (state)
        lane_align_pkg::TX_SYNC:
        begin
          LINK.lane_data <= {4{lane_align_pkg::CHAR_COMMA}};
          LINK.lane_ctrl <= 4'hF;
        end
        lane_align_pkg::TX_ILA, lane_align_pkg::TX_DATA:
        begin
          if (fcnt == lane_align_pkg::MF_LAST)
          begin
            LINK.lane_data <= {4{lane_align_pkg::CHAR_ALIGN}};
            LINK.lane_ctrl <= 4'hF;
          end
          else if (state == lane_align_pkg::TX_DATA && TX_VALID && TX_READY)
          begin
            LINK.lane_data <= {TX_Q[3:0], 4'h0, TX_Q[11:4], TX_I[3:0], 4'h0, TX_I[11:4]};
            LINK.lane_ctrl <= 4'h0;
          end
          else
          begin
            LINK.lane_data <= '0;
            LINK.lane_ctrl <= 4'h0;
          end
        end
        default:
        begin
          LINK.lane_data <= '0;
          LINK.lane_ctrl <= 4'h0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> rtl/lane_link_if.sv
// Decoded four-lane link between transmitter and receiver, plus sync pair.
// Assumes both ends share the frame clock; no clocking block.
`timescale 1ns/1ns
`default_nettype none
interface lane_link_if;
  logic [31:0] lane_data;
  logic [3:0] lane_ctrl;
  logic [3:0] lane_nit_err;
  logic [3:0] lane_kout_unexp;
  logic mds_p;
  logic mds_n;
  modport tx (output lane_data, output lane_ctrl, output lane_nit_err, output lane_kout_unexp,
    output mds_p, output mds_n);
  modport rx (input lane_data, input lane_ctrl, input lane_nit_err, input lane_kout_unexp,
    input mds_p, input mds_n);
endinterface
`default_nettype wire

// >>> verif/lane_align_asserts.sv
// Checker on the lane link and the receiver's alignment status.
// Assumes one frame clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module lane_align_asserts (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic [31:0] lane_data,
  input wire logic [3:0] lane_ctrl,
  input wire logic mds_p,
  input wire logic mds_n,
  input wire logic [3:0] LANE_LOCK,
  input wire logic [1:0] MDS_MODE,
  input wire logic ALIGNED,
  input wire logic SAMPLE_VALID,
  input wire logic MDS_OUT_P,
  input wire logic [2:0] MDS_DELAY
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SRST);
  // ==========================================================
  // Frames since the last align character
  logic is_align;
  logic seen;
  logic [5:0] gap;
  assign is_align = lane_ctrl[0] && lane_data[7:0] == lane_align_pkg::CHAR_ALIGN;
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      seen <= 1'b0;
    else if (is_align)
      seen <= 1'b1;
    else if (lane_ctrl[0] && lane_data[7:0] == lane_align_pkg::CHAR_COMMA)
      seen <= 1'b0;
  end
  always_ff @(posedge MCLK)
  begin
    if (SRST || is_align)
      gap <= 6'h00;
    else
      gap <= gap + 6'h01;
  end
  // ==========================================================
  // Sequences
  sequence s_align;
    is_align;
  endsequence
  sequence s_lock_lost;
    !(&LANE_LOCK);
  endsequence
  sequence s_drop_aligned;
    ##[1:2] !ALIGNED;
  endsequence
  // ==========================================================
  // Properties
  a_align_period: assert property (seen && is_align |-> gap == 6'h1F)
    else $error("align character off its multiframe slot");
  a_align_lanes: assert property (s_align |-> lane_ctrl == 4'hF && lane_data == {4{lane_align_pkg::CHAR_ALIGN}})
    else $error("align character not on all lanes");
  a_mds_pair: assert property (mds_p != mds_n)
    else $error("sync pair not complementary");
  a_mds_pulse: assert property (mds_p |=> !mds_p)
    else $error("sync pulse longer than one frame");
  a_lock_drop: assert property (s_lock_lost |-> s_drop_aligned)
    else $error("still aligned after lock loss");
  a_start_locked: assert property ($rose(ALIGNED) |-> &LANE_LOCK)
    else $error("aligned without lock");
  a_valid_aligned: assert property ($rose(SAMPLE_VALID) |-> ALIGNED)
    else $error("sample valid before alignment");
  a_valid_late: assert property ($rose(ALIGNED) |-> !SAMPLE_VALID)
    else $error("sample valid at alignment edge");
  a_master_only: assert property (MDS_OUT_P |-> MDS_MODE == lane_align_pkg::MDS_MASTER)
    else $error("sync output from non-master");
  a_delay_idle: assert property (MDS_MODE inside {lane_align_pkg::MDS_OFF, lane_align_pkg::MDS_MASTER} |-> MDS_DELAY == 3'h0)
    else $error("sample delay outside slave role");
  a_delay_step: assert property (!$stable(MDS_DELAY) && $stable(MDS_MODE) |->
    (MDS_DELAY > $past(MDS_DELAY) ? MDS_DELAY - $past(MDS_DELAY) : $past(MDS_DELAY) - MDS_DELAY) == 3'h1)
    else $error("sample delay jumped by more than one tap");
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Bench joining transmitter and receiver over the lane link.
// Assumes package, interface and both ends compile first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic MCLK, SRST, START, TX_VALID, TX_READY, MDS_DRIVE, LINK_UP, MANUAL_ALIGN, SCRAMBLE_EN;
  logic MDS_IN_P, MDS_IN_N, BUF_ERR_CLEAR, SAMPLE_VALID, ALIGNED, MDS_OUT_P, MDS_OUT_N;
  logic [11:0] TX_I, TX_Q, I_SAMPLE, Q_SAMPLE, pi, pq;
  logic [4:0] MDS_LEAD;
  logic [3:0] INJECT_NIT, INJECT_KOUT, LANE_LOCK, LANE_BUFFER_ERROR_FLAG;
  logic [1:0] ALIGN_TRIGGER_SELECT, MDS_MODE;
  logic [2:0] MDS_DELAY;
  logic [23:0] last, exp_q[$];
  int errors = 0, samples_checked = 0, align_seen = 0, since_align = 0, cyc = 0;
  int in_phase = 0, hi = 0, hq = 0, m_last = 0, x_last = 0;
  bit collecting = 0, synced = 0, slave_in = 0, lock_d = 0;
  lane_link_if link();
  lane_align_tx u_lane_align_tx (.MCLK(MCLK), .SRST(SRST), .LINK(link), .START(START), .TX_I(TX_I), .TX_Q(TX_Q),
    .TX_VALID(TX_VALID), .TX_READY(TX_READY), .MDS_DRIVE(MDS_DRIVE), .MDS_LEAD(MDS_LEAD),
    .INJECT_NIT(INJECT_NIT), .INJECT_KOUT(INJECT_KOUT), .LINK_UP(LINK_UP));
  lane_align_rx u_lane_align_rx (.MCLK(MCLK), .SRST(SRST), .LINK(link), .LANE_LOCK(LANE_LOCK),
    .ALIGN_TRIGGER_SELECT(ALIGN_TRIGGER_SELECT), .MANUAL_ALIGN(MANUAL_ALIGN), .SCRAMBLE_EN(SCRAMBLE_EN),
    .MDS_MODE(MDS_MODE), .MDS_IN_P(MDS_IN_P), .MDS_IN_N(MDS_IN_N), .BUF_ERR_CLEAR(BUF_ERR_CLEAR),
    .I_SAMPLE(I_SAMPLE), .Q_SAMPLE(Q_SAMPLE), .SAMPLE_VALID(SAMPLE_VALID),
    .LANE_BUFFER_ERROR_FLAG(LANE_BUFFER_ERROR_FLAG), .ALIGNED(ALIGNED), .MDS_OUT_P(MDS_OUT_P),
    .MDS_OUT_N(MDS_OUT_N), .MDS_DELAY(MDS_DELAY));
  lane_align_asserts u_lane_align_asserts (.MCLK(MCLK), .SRST(SRST), .lane_data(link.lane_data),
    .lane_ctrl(link.lane_ctrl), .mds_p(link.mds_p), .mds_n(link.mds_n), .LANE_LOCK(LANE_LOCK),
    .MDS_MODE(MDS_MODE), .ALIGNED(ALIGNED), .SAMPLE_VALID(SAMPLE_VALID), .MDS_OUT_P(MDS_OUT_P),
    .MDS_DELAY(MDS_DELAY));
  // ==========================================================
  // Helpers
  function automatic logic [11:0] pick(input logic [11:0] raw, input logic [11:0] prev, inout int hold);
    pick = hold > 0 ? prev : raw;
    if (hold > 0)
      hold--;
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] want, input string what);
    samples_checked++;
    if (seen !== want)
    begin
      errors++;
      $display("wrong value at %0t ns: %s saw %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
  endtask
  task automatic wait_aligned(input logic want, input int limit);
    int n;
    n = 0;
    while (ALIGNED !== want && n < limit)
    begin
      @(posedge MCLK);
      n++;
    end
    if (ALIGNED !== want)
    begin
      check(ALIGNED, want, "alignment wait");
      give_verdict();
    end
  endtask
  task automatic restart(input logic [1:0] sel, input logic manual);
    @(posedge MCLK);
    collecting = 0;
    slave_in = (sel == 2'h2);
    in_phase = $urandom_range(0, 31);
    SRST <= 1'b1;
    START <= 1'b0;
    LANE_LOCK <= 4'h0;
    TX_VALID <= 1'b0;
    BUF_ERR_CLEAR <= 1'b1;
    ALIGN_TRIGGER_SELECT <= sel;
    MDS_MODE <= sel;
    MANUAL_ALIGN <= manual;
    SCRAMBLE_EN <= sel[0];
    MDS_DRIVE <= (sel == 2'h3);
    MDS_LEAD <= 5'($urandom_range(0, 31));
    tick(6);
    SRST <= 1'b0;
    BUF_ERR_CLEAR <= 1'b0;
  endtask
  task automatic send_data(input int n);
    bit ok;
    int sent;
    sent = 0;
    hi = 0;
    hq = 0;
    synced = 0;
    exp_q.delete();
    collecting = 1;
    TX_VALID <= 1'b1;
    repeat (n)
    begin
      @(posedge MCLK);
      if (TX_VALID && TX_READY)
      begin
        if (|(INJECT_NIT[1:0] | INJECT_KOUT[1:0]))
          hi = SCRAMBLE_EN ? 2 : 1;
        if (|(INJECT_NIT[3:2] | INJECT_KOUT[3:2]))
          hq = SCRAMBLE_EN ? 2 : 1;
        pi = pick(TX_I, pi, hi);
        pq = pick(TX_Q, pq, hq);
        exp_q.push_back({pi, pq});
        sent++;
      end
      ok = sent > 4 && sent % 16 == 8 && since_align >= 2 && since_align <= 24;
      TX_I <= 12'($urandom);
      TX_Q <= 12'($urandom);
      INJECT_NIT <= (ok && sent[5]) ? 4'($urandom_range(1, 15)) : 4'h0;
      INJECT_KOUT <= (ok && !sent[5]) ? 4'($urandom_range(1, 15)) : 4'h0;
    end
    INJECT_NIT <= 4'h0;
    INJECT_KOUT <= 4'h0;
    tick(2);
    check(exp_q.size() <= 20, 1'b1, "sample latency");
    check(synced, 1'b1, "sample stream start");
    collecting = 0;
  endtask
  // ==========================================================
  // Clock, monitors and sync source
  initial
  begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end
  always @(posedge MCLK)
  begin
    cyc <= cyc + 1;
    MDS_IN_P <= slave_in && (cyc % 32 == in_phase);
    MDS_IN_N <= !(slave_in && (cyc % 32 == in_phase));
    since_align <= (link.lane_ctrl[0] && link.lane_data[7:0] == lane_align_pkg::CHAR_ALIGN) ? 0 : since_align + 1;
    // Receiver ignores align characters on the first locked edge
    lock_d <= &LANE_LOCK;
    if (link.lane_ctrl[0] && link.lane_data[7:0] == lane_align_pkg::CHAR_ALIGN && &LANE_LOCK && lock_d)
      align_seen <= align_seen + 1;
    if (!SRST)
      check(MDS_OUT_N, !MDS_OUT_P, "sync out pair");
    if (SRST || !ALIGNED)
      m_last <= 0;
    else if (MDS_OUT_P === 1'b1)
    begin
      if (m_last > 0)
        check(cyc - m_last, 32, "master sync spacing");
      m_last <= cyc;
    end
    if (SRST || !LINK_UP)
      x_last <= 0;
    else if (link.mds_p === 1'b1)
    begin
      if (x_last > 0)
        check(cyc - x_last, 32, "link sync spacing");
      x_last <= cyc;
    end
  end
  always @(posedge MCLK)
  begin
    if (collecting && SAMPLE_VALID === 1'b1)
    begin
      if (!synced)
      begin
        for (int k = 0; k < exp_q.size(); k++)
          if (!synced && exp_q[k] === {I_SAMPLE, Q_SAMPLE})
          begin
            synced = 1;
            repeat (k + 1) last = exp_q.pop_front();
          end
      end
      else if (exp_q.size() > 0 && exp_q[0] === {I_SAMPLE, Q_SAMPLE})
        last = exp_q.pop_front();
      else
        check({I_SAMPLE, Q_SAMPLE}, last, "assembled sample");
    end
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    logic [2:0] d;
    int base;
    SRST = 1'b1;
    {START, TX_VALID, MDS_DRIVE, MANUAL_ALIGN, SCRAMBLE_EN, MDS_IN_P, BUF_ERR_CLEAR} = 7'h00;
    MDS_IN_N = 1'b1;
    {TX_I, TX_Q, MDS_LEAD, INJECT_NIT, INJECT_KOUT, LANE_LOCK, ALIGN_TRIGGER_SELECT, MDS_MODE} = 45'h0;
    void'($urandom(32'hbbe2));
    for (int s = 0; s < 4; s++)
    begin
      restart(2'(s), 1'b0);
      START <= 1'b1;
      tick($urandom_range(1, 60));
      LANE_LOCK <= 4'hF;
      base = align_seen;
      wait_aligned(1'b1, 400);
      check(align_seen - base, s + 1, "align chars before start");
      send_data(300);
      check(LANE_BUFFER_ERROR_FLAG, 4'h0, "buffer flags");
      check(LINK_UP, 1'b1, "link up");
      d = MDS_DELAY;
      tick(64);
      check(MDS_DELAY, d, "slave delay settled");
      // Restart the transmitter off the monitor's frame phase
      base = 0;
      while (since_align != 0 && base < 40)
      begin
        @(posedge MCLK);
        base++;
      end
      START <= 1'b0;
      tick(4);
      START <= 1'b1;
      wait_aligned(1'b0, 150);
      wait_aligned(1'b1, 300);
      LANE_LOCK <= 4'hF & ~(4'h1 << $urandom_range(0, 3));
      wait_aligned(1'b0, 4);
      $display("link test %0d done", s);
    end
    restart(2'h0, 1'b1);
    LANE_LOCK <= 4'hF;
    base = align_seen;
    wait_aligned(1'b1, 8);
    check(align_seen - base, 0, "manual align chars");
    $display("manual test done");
    give_verdict();
  end
endmodule
`default_nettype wire
